// ==== src/daq_external_timing_control.sv ====
// external timing control: triggers, gate, conversion, strobe, dac, mux
//
// Function
// - one scan pulse per conversion
// - scan pulse rise ends sampling phase
// - strobe write gives 500 ns low pulse
// - post-trigger: trigger fall starts acquisition
// - pre-trigger: first fall pre, second post
// - gate low blocks, gate high permits conversions
// - conversion request fall starts one conversion
// - requests outside sequence or gated off ignored
// - timer trigger fall loads both posted dacs when ext_dac_sel is set
// - timer trigger fall raises enabled interrupt
// - exactly one of three input modes
// - single-ended routes any of sixteen inputs
// - differential routes low eight and partner
// - non-referenced mode ties reference node negative
// - other modes ground or float reference node
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module daq_external_timing_control
  import daq_timing_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DEF,
  parameter int SCAN_CYCLES = SCAN_CYCLES_DEF
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic acq_trigger_in_n,
  input wire logic conv_gate_in_n,
  input wire logic conv_request_in_n,
  input wire logic dac_update_trigger_n,
  output logic scan_pulse_out,
  output logic host_write_pulse_n_out,
  output logic adc_start_out,
  output logic [15:0] dac0_value_out,
  output logic [15:0] dac1_value_out,
  output logic dac_load_out,
  output logic irq_out,
  output logic [3:0] mux_pos_sel_out,
  output logic [3:0] mux_neg_sel_out,
  output logic [1:0] neg_route_out,
  output logic ref_to_ground_out,
  output logic acq_active_out
);
  localparam logic [CNT_W-1:0] SAMPLE_LOAD = CNT_W'(SAMPLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] SCAN_LOAD = CNT_W'(SCAN_CYCLES - 1);
  localparam logic [CNT_W-1:0] STROBE_LOAD = CNT_W'(STROBE_CYCLES - 1);
  timing_state_t st;
  timing_state_t next_st;
  logic trig_fall;
  logic gate_level;
  logic conv_fall;
  logic tmr_fall;
  logic acc_wr;
  logic acc_rd;
  logic conv_ok;
  logic [IRQ_W-1:0] irq_set;
  logic [31:0] rd_data;
  logic rd_hit;
  //////////////////////////////////////////////////////////////////////////
  // input synchronisers
  // sync external pins
  edge_sync trig_sync (.mclk_in(mclk_in), .rst_in(rst_in),
    .pin_n_in(acq_trigger_in_n), .level_out(), .fall_out(trig_fall));
  edge_sync gate_sync (.mclk_in(mclk_in), .rst_in(rst_in),
    .pin_n_in(conv_gate_in_n), .level_out(gate_level), .fall_out());
  edge_sync conv_sync (.mclk_in(mclk_in), .rst_in(rst_in),
    .pin_n_in(conv_request_in_n), .level_out(), .fall_out(conv_fall));
  edge_sync tmr_sync (.mclk_in(mclk_in), .rst_in(rst_in),
    .pin_n_in(dac_update_trigger_n), .level_out(), .fall_out(tmr_fall));

  //////////////////////////////////////////////////////////////////////////
  // bus decode and read mux
  assign acc_wr = psel_in & penable_in & st.pready & pwrite_in;
  assign acc_rd = psel_in & penable_in & ~st.pready;
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr_in)
      CTRL_OFS: rd_data = 32'(st.ctrl);
      CHAN_OFS: rd_data = 32'(st.chan);
      STROBE_OFS: rd_data = 32'h0000_0000;
      DAC0_OFS: rd_data = 32'(st.dac0_wr);
      DAC1_OFS: rd_data = 32'(st.dac1_wr);
      POSTCNT_OFS: rd_data = 32'(st.post_count);
      CMD_OFS: rd_data = 32'h0000_0000;
      STATUS_OFS: rd_data = {st.conv_total, 11'h000, ~gate_level,
                             st.conv, st.acq};
      IRQ_STAT_OFS: rd_data = 32'(st.irq_stat);
      IRQ_MASK_OFS: rd_data = 32'(st.irq_mask);
      default: rd_hit = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // next-state logic
  // gate permits starts
  assign conv_ok = conv_fall & gate_level & (st.conv == conv_idle) &
                   ((st.acq == acq_pre) || (st.acq == acq_post));
  always_comb begin
    next_st = st;
    irq_set = '0;
    next_st.adc_start = 1'b0;
    next_st.dac_load = 1'b0;
    next_st.pready = acc_rd;
    next_st.pslverr = acc_rd & ~rd_hit;
    if (acc_rd) begin
      next_st.prdata = rd_data;
    end
    if (acc_wr) begin
      unique case (paddr_in)
        CTRL_OFS: begin
          if (pwdata_in[1:0] != 2'h3) begin
            next_st.ctrl = ctrl_t'(pwdata_in[CTRL_W-1:0]);
          end
        end
        CHAN_OFS: next_st.chan = pwdata_in[3:0];
        STROBE_OFS: begin
          next_st.strobe_n = 1'b0;
          next_st.strobe_cnt = STROBE_LOAD;
        end
        DAC0_OFS: next_st.dac0_wr = pwdata_in[15:0];
        DAC1_OFS: next_st.dac1_wr = pwdata_in[15:0];
        POSTCNT_OFS: next_st.post_count = pwdata_in[15:0];
        IRQ_MASK_OFS: next_st.irq_mask = pwdata_in[IRQ_W-1:0];
        default: begin
        end
      endcase
    end

    if (!st.strobe_n && !(acc_wr && paddr_in == STROBE_OFS)) begin
      if (st.strobe_cnt == '0) begin
        next_st.strobe_n = 1'b1;
      end else begin
        next_st.strobe_cnt = st.strobe_cnt - 1'b1;
      end
    end

    // direct update when posting is off
    if (acc_wr && !st.ctrl.posted &&
        (paddr_in == DAC0_OFS || paddr_in == DAC1_OFS)) begin
      next_st.dac0 = next_st.dac0_wr;
      next_st.dac1 = next_st.dac1_wr;
      next_st.dac_load = 1'b1;
    end
    if (tmr_fall && st.ctrl.posted && st.ctrl.ext_dac_sel) begin
      next_st.dac0 = st.dac0_wr;
      next_st.dac1 = st.dac1_wr;
      next_st.dac_load = 1'b1;
    end
    if (tmr_fall) begin
      irq_set[IRQ_TIMER_BIT] = 1'b1;
    end
    unique case (st.acq)
      acq_idle: begin
      end
      acq_armed: begin
        if (trig_fall) begin
          irq_set[IRQ_ACQ_START_BIT] = 1'b1;
          next_st.acq = st.ctrl.pretrig ? acq_pre : acq_post;
        end
      end
      acq_pre: begin
        if (trig_fall) begin
          next_st.acq = acq_post;
        end
      end
      acq_post: begin
        if (conv_ok) begin
          next_st.post_done = st.post_done + 16'h0001;
          if (st.post_done + 16'h0001 >= st.post_count) begin
            next_st.acq = acq_idle;
            irq_set[IRQ_ACQ_DONE_BIT] = 1'b1;
          end
        end
      end
    endcase

    if (acc_wr && paddr_in == CMD_OFS) begin
      if (pwdata_in[CMD_ABORT_BIT]) begin
        next_st.acq = acq_idle;
      end else if (pwdata_in[CMD_ARM_BIT]) begin
        next_st.acq = acq_armed;
        next_st.post_done = 16'h0000;
      end
    end

    unique case (st.conv)
      conv_idle: begin
        if (conv_ok) begin
          next_st.adc_start = 1'b1;
          next_st.conv_cnt = SAMPLE_LOAD;
          next_st.conv = conv_sample;
        end
      end
      conv_sample: begin
        if (st.conv_cnt == '0) begin
          next_st.scan = 1'b1;
          next_st.conv_cnt = SCAN_LOAD;
          next_st.conv = conv_scan;
        end else begin
          next_st.conv_cnt = st.conv_cnt - 1'b1;
        end
      end
      conv_scan: begin
        if (st.conv_cnt == '0) begin
          next_st.scan = 1'b0;
          next_st.conv = conv_idle;
          next_st.conv_total = st.conv_total + 16'h0001;
        end else begin
          next_st.conv_cnt = st.conv_cnt - 1'b1;
        end
      end
      default: next_st.conv = conv_idle;
    endcase

    // set wins over write-one clear
    next_st.irq_stat = st.irq_stat | irq_set;
    if (acc_wr && paddr_in == IRQ_STAT_OFS) begin
      next_st.irq_stat = (st.irq_stat & ~pwdata_in[IRQ_W-1:0]) | irq_set;
    end
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
    next_st.acq_active = (next_st.acq == acq_pre) || (next_st.acq == acq_post);
    next_st.pos_sel = next_st.chan;
    next_st.neg_sel = 4'h0;
    next_st.ref_ground = 1'b0;
    unique case (next_st.ctrl.mode)
      nonref_single_ended_mode: begin
        next_st.neg_route = neg_to_ref_node;
      end
      ref_single_ended_mode: begin
        next_st.neg_route = neg_to_ground;
        next_st.ref_ground = next_st.ctrl.sense_ground;
      end
      two_wire_input_mode: begin
        next_st.pos_sel = {1'b0, next_st.chan[2:0]};
        next_st.neg_sel = {1'b1, next_st.chan[2:0]};
        next_st.neg_route = neg_to_channel;
        next_st.ref_ground = next_st.ctrl.sense_ground;
      end
      default: next_st.neg_route = neg_to_ref_node;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
      st.strobe_n <= 1'b1;
      st.post_count <= POSTCNT_RST;
      st.ctrl <= CTRL_RST;
      st.neg_route <= neg_to_ref_node;
      st.acq <= acq_idle;
      st.conv <= conv_idle;
    end else begin
      st <= next_st;
    end
  end
  assign prdata_out = st.prdata;
  assign pready_out = st.pready;
  assign pslverr_out = st.pslverr;
  assign scan_pulse_out = st.scan;
  assign host_write_pulse_n_out = st.strobe_n;
  assign adc_start_out = st.adc_start;
  assign dac0_value_out = st.dac0;
  assign dac1_value_out = st.dac1;
  assign dac_load_out = st.dac_load;
  assign irq_out = st.irq;
  assign mux_pos_sel_out = st.pos_sel;
  assign mux_neg_sel_out = st.neg_sel;
  assign neg_route_out = st.neg_route;
  assign ref_to_ground_out = st.ref_ground;
  assign acq_active_out = st.acq_active;

  //////////////////////////////////////////////////////////////////////////
  // checks
  logic [CNT_W-1:0] low_len;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      low_len <= '0;
    end else if (!st.strobe_n) begin
      low_len <= low_len + 1'b1;
    end else begin
      low_len <= '0;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence conv_begin_s;
    $rose(st.adc_start);
  endsequence
  sequence scan_window_s;
    $rose(st.scan) ##1 st.scan [*1] ##(SCAN_CYCLES - 1) $fell(st.scan);
  endsequence
  scan_after_sample_a: assert property (
    conv_begin_s |-> ##SAMPLE_CYCLES scan_window_s)
    else $error("scan pulse not timed after sampling");
  one_scan_per_conv_a: assert property (
    $rose(st.scan) |-> $past(st.conv) == conv_sample)
    else $error("scan pulse without conversion");
  strobe_width_a: assert property (
    $rose(st.strobe_n) |-> low_len >= CNT_W'(STROBE_CYCLES))
    else $error("strobe pulse too short");
  strobe_start_a: assert property (
    acc_wr && paddr_in == STROBE_OFS |=> !st.strobe_n)
    else $error("strobe write gave no pulse");
  post_trigger_a: assert property (
    st.acq == acq_armed && trig_fall && !st.ctrl.pretrig && !acc_wr
    |=> st.acq == acq_post)
    else $error("trigger did not start post sequence");
  pre_trigger_a: assert property (
    st.acq == acq_pre && trig_fall && !acc_wr |=> st.acq == acq_post)
    else $error("second trigger did not start post part");
  gate_block_a: assert property (
    !gate_level |=> !st.adc_start)
    else $error("conversion started while gated off");
  idle_ignore_a: assert property (
    (st.acq == acq_idle || st.acq == acq_armed) |=> !st.adc_start)
    else $error("conversion outside sequence");
  dac_posted_a: assert property (
    tmr_fall && st.ctrl.posted && st.ctrl.ext_dac_sel
    |=> dac_load_out && dac0_value_out == $past(st.dac0_wr))
    else $error("posted dac update missing");
  timer_irq_a: assert property (
    tmr_fall && st.irq_mask[IRQ_TIMER_BIT] && !acc_wr |=> irq_out)
    else $error("timer interrupt not raised");
  mode_legal_a: assert property (
    st.ctrl.mode != 2'h3)
    else $error("illegal input mode held");
  two_wire_input_mode_route_a: assert property (
    st.neg_route == neg_to_channel |->
    st.neg_sel == {1'b1, st.pos_sel[2:0]} && !st.pos_sel[3])
    else $error("differential pairing wrong");

endmodule
`default_nettype wire

// ==== inc/daq_timing_pkg.sv ====
// constants, register map and state types for the external timing block
package daq_timing_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_MIN_NS = 500;
  localparam int STROBE_CYCLES =
    (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CYCLES_DEF = 20;
  localparam int SCAN_CYCLES_DEF = 20;
  localparam int CNT_W = 8;

  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CHAN_OFS = 8'h04;
  localparam logic [7:0] STROBE_OFS = 8'h08;
  localparam logic [7:0] DAC0_OFS = 8'h0C;
  localparam logic [7:0] DAC1_OFS = 8'h10;
  localparam logic [7:0] POSTCNT_OFS = 8'h14;
  localparam logic [7:0] CMD_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1C;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h24;

  localparam int CMD_ARM_BIT = 0;
  localparam int CMD_ABORT_BIT = 1;
  localparam int IRQ_TIMER_BIT = 0;
  localparam int IRQ_ACQ_START_BIT = 1;
  localparam int IRQ_ACQ_DONE_BIT = 2;
  localparam int IRQ_W = 3;
  localparam int CTRL_W = 6;

  localparam logic [15:0] POSTCNT_RST = 16'h0001;

  typedef enum logic [1:0] {
    nonref_single_ended_mode,
    ref_single_ended_mode,
    two_wire_input_mode
  } input_mode_t;

  typedef enum logic [1:0] {
    neg_to_ground,
    neg_to_ref_node,
    neg_to_channel
  } neg_route_t;

  typedef enum logic [1:0] {acq_idle, acq_armed, acq_pre, acq_post} acq_state_t;
  typedef enum logic [1:0] {conv_idle, conv_sample, conv_scan} conv_state_t;

  typedef struct packed {
    logic ext_dac_sel;
    logic posted;
    logic pretrig;
    logic sense_ground;
    input_mode_t mode;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = ctrl_t'(6'h00);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic fall;
  } sync_state_t;

  localparam sync_state_t SYNC_RST = sync_state_t'(4'hE);

  typedef struct packed {
    ctrl_t ctrl;
    logic [3:0] chan;
    logic [15:0] dac0_wr;
    logic [15:0] dac1_wr;
    logic [15:0] dac0;
    logic [15:0] dac1;
    logic dac_load;
    logic [15:0] post_count;
    logic [15:0] post_done;
    acq_state_t acq;
    conv_state_t conv;
    logic [CNT_W-1:0] conv_cnt;
    logic [15:0] conv_total;
    logic [CNT_W-1:0] strobe_cnt;
    logic strobe_n;
    logic scan;
    logic adc_start;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
    neg_route_t neg_route;
    logic ref_ground;
    logic acq_active;
  } timing_state_t;

endpackage

// ==== src/edge_sync.sv ====
// two-flop synchroniser with registered falling-edge pulse
`timescale 1ns/1ps
`default_nettype none
module edge_sync
  import daq_timing_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic pin_n_in,
  output logic level_out,
  output logic fall_out
);

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.meta = pin_n_in;
    next_st.sync = st.meta;
    next_st.last = st.sync;
    next_st.fall = st.last & ~st.sync;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= SYNC_RST;
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.sync;
  assign fall_out = st.fall;

endmodule
`default_nettype wire

// ==== verification/field_equipment.sv ====
// field-side model that drives the external timing pins
`timescale 1ns/1ps
`default_nettype none
module field_equipment (
  input wire logic mclk_in,
  output logic acq_trig_n_out,
  output logic gate_n_out,
  output logic conv_req_n_out,
  output logic timer_trig_n_out
);
  // pins idle high through pull-ups
  logic [3:0] pins_n = 4'hf;
  assign acq_trig_n_out = pins_n[0];
  assign gate_n_out = pins_n[1];
  assign conv_req_n_out = pins_n[2];
  assign timer_trig_n_out = pins_n[3];
  ////////////////////////////////////////////////////////////////////////////
  // one clean low pulse, long enough for the synchroniser
  task automatic strike(input int idx);
    @(posedge mclk_in);
    pins_n[idx] <= 1'b0;
    repeat (4) @(posedge mclk_in);
    pins_n[idx] <= 1'b1;
    repeat (4) @(posedge mclk_in);
  endtask
  // gate is a level, low blocks
  task automatic set_gate(input logic lvl);
    @(posedge mclk_in);
    pins_n[1] <= lvl;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking testbench for the external timing block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import daq_timing_pkg::*;
  localparam int TRIG = 0;
  localparam int REQ = 2;
  localparam int TMR = 3;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, scan_pulse_out, host_write_pulse_n_out;
  logic acq_trigger_in_n, conv_gate_in_n, conv_request_in_n;
  logic dac_update_trigger_n, adc_start_out, dac_load_out, irq_out;
  logic [15:0] dac0_value_out, dac1_value_out;
  logic [3:0] mux_pos_sel_out, mux_neg_sel_out;
  logic [1:0] neg_route_out;
  logic ref_to_ground_out, acq_active_out, scan_q, er;
  logic [31:0] rd;
  int error_cnt = 0;
  int comparisons = 0;
  int n_start = 0;
  int n_scan = 0;
  int n_load = 0;
  int cycle = 0;
  int t_start = 0;
  int d_scan = 0;

  daq_external_timing_control #(.SAMPLE_CYCLES(2), .SCAN_CYCLES(2))
    daq_external_timing_control_i (
    .mclk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .acq_trigger_in_n, .conv_gate_in_n, .conv_request_in_n,
    .dac_update_trigger_n, .scan_pulse_out, .host_write_pulse_n_out,
    .adc_start_out, .dac0_value_out, .dac1_value_out, .dac_load_out,
    .irq_out, .mux_pos_sel_out, .mux_neg_sel_out, .neg_route_out,
    .ref_to_ground_out, .acq_active_out);

  field_equipment field_equipment_i (
    .mclk_in,
    .acq_trig_n_out(acq_trigger_in_n),
    .gate_n_out(conv_gate_in_n),
    .conv_req_n_out(conv_request_in_n),
    .timer_trig_n_out(dac_update_trigger_n));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  // pulse monitors
  always @(posedge mclk_in) begin
    cycle++;
    if (adc_start_out === 1'b1) begin
      n_start++;
      t_start = cycle;
    end
    if (scan_pulse_out === 1'b1 && scan_q !== 1'b1) begin
      n_scan++;
      d_scan = cycle - t_start;
    end
    if (dac_load_out === 1'b1) begin
      n_load++;
    end
    scan_q = scan_pulse_out;
  end
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic hit(input int i);
    field_equipment_i.strike(i);
    cyc(2);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {16'h0000, d};
    @(posedge mclk_in);
    penable_in <= 1'b1;
    // hold the request until pready is sampled high at a rising edge
    do begin
      @(posedge mclk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_strobe();
    int lo;
    lo = 0;
    wr(STROBE_OFS, 16'h0001);
    @(negedge mclk_in);
    while (host_write_pulse_n_out === 1'b0 && lo < 200) begin
      lo++;
      @(negedge mclk_in);
    end
    chk(16'(lo), 16'(STROBE_CYCLES));
  endtask
  task automatic t_mux();
    wr(CHAN_OFS, 16'h000b);
    for (int m = 0; m < 3; m++) begin
      wr(CTRL_OFS, 16'(4 + m));
      cyc(2);
      chk(16'(mux_pos_sel_out), (m == 2) ? 16'h0003 : 16'h000b);
      chk(16'(mux_neg_sel_out), (m == 2) ? 16'h000b : 16'h0000);
      chk(16'(neg_route_out), (m == 0) ? 16'h0001 : 16'(2*m-2));
      chk(16'(ref_to_ground_out), (m == 0) ? 16'h0000 : 16'h0001);
    end
    wr(CTRL_OFS, 16'h0001);
    cyc(2);
    chk(16'(ref_to_ground_out), 16'h0000);
    chk(16'(neg_route_out), 16'h0000);
    wr(CTRL_OFS, 16'h0007);
    rdr(CTRL_OFS);
    chk(rd[15:0], 16'h0001);
  endtask
  task automatic t_post();
    int s;
    wr(CTRL_OFS, 16'h0000);
    wr(POSTCNT_OFS, 16'h0002);
    s = n_start;
    hit(REQ);
    chk(16'(n_start), 16'(s));
    wr(CMD_OFS, 16'h0001);
    hit(TRIG);
    chk(16'(acq_active_out), 16'h0001);
    field_equipment_i.set_gate(1'b0);
    cyc(6);
    hit(REQ);
    chk(16'(n_start), 16'(s));
    field_equipment_i.set_gate(1'b1);
    cyc(6);
    hit(REQ);
    chk(16'(n_start), 16'(s + 1));
    chk(16'(n_scan), 16'(n_start));
    chk(16'(d_scan), 16'h0002);
    hit(REQ);
    chk(16'(n_start), 16'(s + 2));
    chk(16'(acq_active_out), 16'h0000);
  endtask
  task automatic t_pre();
    wr(CTRL_OFS, 16'h0008);
    wr(CMD_OFS, 16'h0001);
    hit(TRIG);
    rdr(STATUS_OFS);
    chk(16'(rd[1:0]), 16'h0002);
    hit(TRIG);
    rdr(STATUS_OFS);
    chk(16'(rd[1:0]), 16'h0003);
    wr(CMD_OFS, 16'h0002);
  endtask
  task automatic t_dac();
    int l;
    wr(IRQ_STAT_OFS, 16'h0007);
    wr(CTRL_OFS, 16'h0030);
    wr(DAC0_OFS, 16'h1234);
    wr(DAC1_OFS, 16'habcd);
    cyc(2);
    chk(dac0_value_out, 16'h0000);
    l = n_load;
    hit(TMR);
    chk(dac0_value_out, 16'h1234);
    chk(dac1_value_out, 16'habcd);
    chk(16'(n_load), 16'(l + 1));
    chk(16'(irq_out), 16'h0000);
    rdr(IRQ_STAT_OFS);
    chk(16'(rd[0]), 16'h0001);
    wr(IRQ_MASK_OFS, 16'h0001);
    cyc(2);
    chk(16'(irq_out), 16'h0001);
    wr(IRQ_STAT_OFS, 16'h0001);
    cyc(2);
    chk(16'(irq_out), 16'h0000);
    hit(TMR);
    chk(16'(irq_out), 16'h0001);
    wr(IRQ_STAT_OFS, 16'h0001);
    wr(CTRL_OFS, 16'h0000);
    wr(DAC0_OFS, 16'h5555);
    cyc(2);
    chk(dac0_value_out, 16'h5555);
    chk(dac1_value_out, 16'habcd);
    wr(CTRL_OFS, 16'h0010);
    wr(DAC1_OFS, 16'h7777);
    l = n_load;
    hit(TMR);
    chk(16'(n_load), 16'(l));
    chk(dac1_value_out, 16'habcd);
    rdr(8'h3c);
    chk({15'h0000, er}, 16'h0001);
    chk(rd[15:0], 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // verdict
  task automatic final_report();
    $display("errors=%0d compares=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end
  initial begin
    cyc(10);
    rst_in <= 1'b0;
    cyc(4);
    chk(16'(host_write_pulse_n_out), 16'h0001);
    chk(16'(neg_route_out), 16'h0001);
    t_strobe();
    t_mux();
    t_post();
    t_pre();
    t_dac();
    final_report();
  end
endmodule
`default_nettype wire
